// File: design/otnc_map.vh
`ifndef OTNC_MAP_VH
`define OTNC_MAP_VH

// register addresses
`define OTNC_ADDR_FEAT      8'h5e
`define OTNC_ADDR_IERR      8'h5f
`define OTNC_ADDR_UNLOCK    8'h6a
`define OTNC_ADDR_IFSETUP   8'h6b
`define OTNC_ADDR_SELFTEST  8'h6d
`define OTNC_ADDR_NVCFG     8'h70
`define OTNC_ADDR_OFFX      8'h71
`define OTNC_ADDR_OFFY      8'h72
`define OTNC_ADDR_OFFZ      8'h73
`define OTNC_ADDR_PWRCFG    8'h7c
`define OTNC_ADDR_PWRCTL    8'h7d
`define OTNC_ADDR_CMD       8'h7e
`define OTNC_ADDR_STATUS    8'h03

// field positions
`define OTNC_BIT_OFF_EN     3
`define OTNC_BIT_PROG_EN    1
`define OTNC_BIT_APS        0
`define OTNC_BIT_CMD_RDY    4

// reset values
`define OTNC_RST_PWRCFG     8'h03
`define OTNC_RST_ZERO       8'h00

// commands
`define OTNC_CMD_SOFTRST    8'hb6
`define OTNC_CMD_NVMPROG    8'ha0

// timing
`define OTNC_BOOT_US        1000
`define OTNC_PROG_US        40000
`define OTNC_CLK_MHZ        100

`endif

// File: design/otnc_offset_trim_nvm.v
// Contract
// - offset computed on raw samples, applied to raw and filtered outputs
// - overflowing corrected sample saturates to min or max by sign
// - image update copies stored offsets into the three offset registers
// - host may overwrite offset registers any time until next image update
// - offsets are 8-bit two's complement, 3.9 mg step, range independent
// - correction applied only while offset-enable config bit is one
// - after an offset register write the next sample is flagged invalid
// - after reset or soft reset load NVM; command-ready low during load
// - NVM programming rewrites every location from the image registers
// - command-ready low during programming, high when finished
// - programming starts only if power-save bit is zero at command
// - serial interface silent until boot load finishes
// - while NVM busy, writes dropped and reads return status
// - writing 0xb6 to command register triggers soft reset
// - soft reset restores defaults, from NVM where stored
// - feature port access needs power save at zero
`timescale 1ns/1ps
`include "otnc_map.vh"

module otnc_offset_trim_nvm #(
    parameter DATA_W      = 16,
    parameter OFF_SHIFT   = 4,
    parameter BOOT_CYCLES = `OTNC_BOOT_US * `OTNC_CLK_MHZ,
    parameter PROG_CYCLES = `OTNC_PROG_US * `OTNC_CLK_MHZ,
    parameter CNT_W       = 24
) (
    // clock and reset
    input  wire              clk,
    input  wire              sys_rst,
    // register access port
    input  wire              regWrStb,
    input  wire              regRdStb,
    input  wire [7:0]        regAddr,
    input  wire [7:0]        regWrData,
    output reg  [7:0]        regRdData,
    output reg               regRdValid,
    output reg               ifReady,
    // sample path
    input  wire              sampleStb,
    input  wire [DATA_W-1:0] rawX,
    input  wire [DATA_W-1:0] rawY,
    input  wire [DATA_W-1:0] rawZ,
    input  wire [DATA_W-1:0] filtX,
    input  wire [DATA_W-1:0] filtY,
    input  wire [DATA_W-1:0] filtZ,
    output reg  [DATA_W-1:0] rawOutX,
    output reg  [DATA_W-1:0] rawOutY,
    output reg  [DATA_W-1:0] rawOutZ,
    output reg  [DATA_W-1:0] filtOutX,
    output reg  [DATA_W-1:0] filtOutY,
    output reg  [DATA_W-1:0] filtOutZ,
    output reg               sampleValid,
    output reg               sampleOk,
    // control levels and soft reset pulse to rest of sensor
    output reg  [7:0]        powerConfigOut,
    output reg  [7:0]        featureOut,
    output reg               softResetPulse
);

    localparam ST_BOOT = 3'b001;
    localparam ST_IDLE = 3'b010;
    localparam ST_PROG = 3'b100;

    reg [2:0]       state_reg;
    reg [CNT_W-1:0] busyCnt_reg;
    // nvm store: index 0 config, 1..3 offsets
    reg [7:0]       nvm_reg [0:3];
    reg [7:0]       nvConfig_reg;
    reg [7:0]       offX_reg;
    reg [7:0]       offY_reg;
    reg [7:0]       offZ_reg;
    reg [7:0]       unlock_reg;
    reg [7:0]       ifSetup_reg;
    reg [7:0]       selfTest_reg;
    reg [7:0]       pwrCtl_reg;
    reg             offDirty_reg;
    integer         i;

    wire busy    = ~state_reg[1];
    wire cmdRdy  = state_reg[1];
    wire apsBit  = powerConfigOut[`OTNC_BIT_APS];
    wire offEn   = nvConfig_reg[`OTNC_BIT_OFF_EN];
    wire [7:0] statusVal = {3'h0, cmdRdy, 4'h0};

    // 8-bit offset at 3.9 mg scaled onto sample lsb
    function [DATA_W-1:0] corr;
        input [DATA_W-1:0] s;
        input [7:0]        o;
        input              en;
        reg   [DATA_W:0]   sum;
        reg   [DATA_W:0]   oExt;
        begin
            oExt = {{(DATA_W+1-8){o[7]}}, o} <<< OFF_SHIFT;
            sum  = {s[DATA_W-1], s} + (en ? oExt : {(DATA_W+1){1'b0}});
            if (sum[DATA_W] != sum[DATA_W-1])
                corr = sum[DATA_W] ? {1'b1, {(DATA_W-1){1'b0}}}
                                   : {1'b0, {(DATA_W-1){1'b1}}};
            else
                corr = sum[DATA_W-1:0];
        end
    endfunction

    // register read mux
    function [7:0] rdMux;
        input [7:0] a;
        begin
            case (a)
                `OTNC_ADDR_STATUS:   rdMux = statusVal;
                `OTNC_ADDR_FEAT:     rdMux = apsBit ? 8'h00 : featureOut;
                `OTNC_ADDR_IERR:     rdMux = 8'h00;
                `OTNC_ADDR_UNLOCK:   rdMux = unlock_reg & 8'h02;
                `OTNC_ADDR_IFSETUP:  rdMux = ifSetup_reg & 8'h11;
                `OTNC_ADDR_SELFTEST: rdMux = selfTest_reg & 8'h0d;
                `OTNC_ADDR_NVCFG:    rdMux = nvConfig_reg & 8'h0f;
                `OTNC_ADDR_OFFX:     rdMux = offX_reg;
                `OTNC_ADDR_OFFY:     rdMux = offY_reg;
                `OTNC_ADDR_OFFZ:     rdMux = offZ_reg;
                `OTNC_ADDR_PWRCFG:   rdMux = powerConfigOut & 8'h03;
                `OTNC_ADDR_PWRCTL:   rdMux = pwrCtl_reg & 8'h05;
                default:             rdMux = 8'h00;
            endcase
        end
    endfunction

    wire hostWr = regWrStb & ~busy;
    wire offWr  = hostWr & (regAddr == `OTNC_ADDR_OFFX ||
                            regAddr == `OTNC_ADDR_OFFY ||
                            regAddr == `OTNC_ADDR_OFFZ);
    wire cmdWr  = hostWr & (regAddr == `OTNC_ADDR_CMD);

    // boot, idle and programming sequencer
    always @(posedge clk) begin
        if (sys_rst) begin
            state_reg      <= ST_BOOT;
            busyCnt_reg    <= BOOT_CYCLES[CNT_W-1:0];
            nvConfig_reg   <= `OTNC_RST_ZERO;
            offX_reg       <= `OTNC_RST_ZERO;
            offY_reg       <= `OTNC_RST_ZERO;
            offZ_reg       <= `OTNC_RST_ZERO;
            unlock_reg     <= `OTNC_RST_ZERO;
            ifSetup_reg    <= `OTNC_RST_ZERO;
            selfTest_reg   <= `OTNC_RST_ZERO;
            pwrCtl_reg     <= `OTNC_RST_ZERO;
            powerConfigOut <= `OTNC_RST_PWRCFG;
            featureOut     <= `OTNC_RST_ZERO;
            softResetPulse <= 1'b0;
            ifReady        <= 1'b0;
            offDirty_reg   <= 1'b0;
            for (i = 0; i < 4; i = i + 1)
                nvm_reg[i] <= 8'h00;
        end else begin
            softResetPulse <= 1'b0;
            case (state_reg)
                ST_BOOT: begin
                    ifReady <= 1'b0;
                    if (busyCnt_reg == {CNT_W{1'b0}}) begin
                        nvConfig_reg <= nvm_reg[0];
                        offX_reg     <= nvm_reg[1];
                        offY_reg     <= nvm_reg[2];
                        offZ_reg     <= nvm_reg[3];
                        offDirty_reg <= 1'b1;
                        state_reg    <= ST_IDLE;
                        ifReady      <= 1'b1;
                    end else begin
                        busyCnt_reg <= busyCnt_reg - 1'b1;
                    end
                end
                ST_IDLE: begin
                    if (cmdWr && regWrData == `OTNC_CMD_SOFTRST) begin
                        state_reg      <= ST_BOOT;
                        busyCnt_reg    <= BOOT_CYCLES[CNT_W-1:0];
                        softResetPulse <= 1'b1;
                        ifReady        <= 1'b0;
                        unlock_reg     <= `OTNC_RST_ZERO;
                        ifSetup_reg    <= `OTNC_RST_ZERO;
                        selfTest_reg   <= `OTNC_RST_ZERO;
                        pwrCtl_reg     <= `OTNC_RST_ZERO;
                        powerConfigOut <= `OTNC_RST_PWRCFG;
                        featureOut     <= `OTNC_RST_ZERO;
                    end else if (cmdWr && regWrData == `OTNC_CMD_NVMPROG &&
                                 !apsBit && unlock_reg[`OTNC_BIT_PROG_EN]) begin
                        state_reg   <= ST_PROG;
                        busyCnt_reg <= PROG_CYCLES[CNT_W-1:0];
                    end else if (hostWr) begin
                        case (regAddr)
                            `OTNC_ADDR_NVCFG:    nvConfig_reg <= regWrData & 8'h0f;
                            `OTNC_ADDR_OFFX:     offX_reg <= regWrData;
                            `OTNC_ADDR_OFFY:     offY_reg <= regWrData;
                            `OTNC_ADDR_OFFZ:     offZ_reg <= regWrData;
                            `OTNC_ADDR_UNLOCK:   unlock_reg <= regWrData & 8'h02;
                            `OTNC_ADDR_IFSETUP:  ifSetup_reg <= regWrData & 8'h11;
                            `OTNC_ADDR_SELFTEST: selfTest_reg <= regWrData & 8'h0d;
                            `OTNC_ADDR_PWRCFG:   powerConfigOut <= regWrData & 8'h03;
                            `OTNC_ADDR_PWRCTL:   pwrCtl_reg <= regWrData & 8'h05;
                            `OTNC_ADDR_FEAT: begin
                                if (!apsBit)
                                    featureOut <= regWrData;
                            end
                            default: ;
                        endcase
                    end
                    // set wins over the sample that would clear it
                    if (offWr)
                        offDirty_reg <= 1'b1;
                    else if (sampleStb)
                        offDirty_reg <= 1'b0;
                end
                ST_PROG: begin
                    if (busyCnt_reg == {CNT_W{1'b0}}) begin
                        nvm_reg[0] <= nvConfig_reg;
                        nvm_reg[1] <= offX_reg;
                        nvm_reg[2] <= offY_reg;
                        nvm_reg[3] <= offZ_reg;
                        state_reg  <= ST_IDLE;
                    end else begin
                        busyCnt_reg <= busyCnt_reg - 1'b1;
                    end
                end
                default: begin
                    state_reg   <= ST_BOOT;
                    busyCnt_reg <= BOOT_CYCLES[CNT_W-1:0];
                end
            endcase
        end
    end

    // register reads
    always @(posedge clk) begin
        if (sys_rst) begin
            regRdData  <= 8'h00;
            regRdValid <= 1'b0;
        end else begin
            regRdValid <= regRdStb & ifReady;
            if (regRdStb)
                regRdData <= busy ? statusVal : rdMux(regAddr);
        end
    end

    // corrected sample outputs
    always @(posedge clk) begin
        if (sys_rst) begin
            rawOutX     <= {DATA_W{1'b0}};
            rawOutY     <= {DATA_W{1'b0}};
            rawOutZ     <= {DATA_W{1'b0}};
            filtOutX    <= {DATA_W{1'b0}};
            filtOutY    <= {DATA_W{1'b0}};
            filtOutZ    <= {DATA_W{1'b0}};
            sampleValid <= 1'b0;
            sampleOk    <= 1'b0;
        end else begin
            sampleValid <= sampleStb;
            if (sampleStb) begin
                rawOutX  <= corr(rawX, offX_reg, offEn);
                rawOutY  <= corr(rawY, offY_reg, offEn);
                rawOutZ  <= corr(rawZ, offZ_reg, offEn);
                filtOutX <= corr(filtX, offX_reg, offEn);
                filtOutY <= corr(filtY, offY_reg, offEn);
                filtOutZ <= corr(filtZ, offZ_reg, offEn);
                sampleOk <= ~offDirty_reg & ~offWr;
            end
        end
    end

endmodule // otnc_offset_trim_nvm

// File: test/otnc_host_model.sv
`timescale 1ns/1ps
module otnc_host_model (
    // clock
    input  wire logic       clk,
    // register port
    output logic            regWrStb,
    output logic            regRdStb,
    output logic [7:0]      regAddr,
    output logic [7:0]      regWrData,
    input  wire logic [7:0] regRdData,
    input  wire logic       regRdValid
);
    initial begin
        regWrStb = 1'b0;
        regRdStb = 1'b0;
        regAddr = 8'h00;
        regWrData = 8'h00;
    end
    // released lines show the inverse of the last value
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge clk);
        regWrStb = 1'b1;
        regAddr = a;
        regWrData = v;
        @(negedge clk);
        regWrStb = 1'b0;
        regAddr = ~a;
        regWrData = ~v;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(negedge clk);
        regRdStb = 1'b1;
        regAddr = a;
        @(negedge clk);
        regRdStb = 1'b0;
        regAddr = ~a;
        if (!regRdValid) @(negedge clk);
        v = regRdValid ? regRdData : 8'hxx;
    endtask
    task automatic prog_start(input logic [31:0] img);
        wr(8'h7c, 8'h02);
        for (int i = 0; i < 4; i++) wr(8'(8'h70 + i), img[8*i +: 8]);
        wr(8'h6a, 8'h02);
        wr(8'h7e, 8'ha0);
    endtask
    // only status is polled while busy, no soft reset meanwhile
    task automatic prog_wait();
        logic [7:0] s;
        s = 8'h00;
        for (int i = 0; i < 40 && !s[4]; i++) rd(8'h03, s);
        wr(8'h6a, 8'h00);
    endtask
endmodule // otnc_host_model

// File: test/otnc_offset_trim_nvm_props.sv
`timescale 1ns/1ps
module otnc_offset_trim_nvm_props (
    // clock and reset
    input wire logic        clk,
    input wire logic        sys_rst,
    // register port
    input wire logic        regWrStb,
    input wire logic        regRdStb,
    input wire logic [7:0]  regAddr,
    input wire logic [7:0]  regWrData,
    input wire logic        regRdValid,
    input wire logic        ifReady,
    // samples
    input wire logic        sampleStb,
    input wire logic [15:0] rawX,
    input wire logic [15:0] filtX,
    input wire logic [15:0] rawOutX,
    input wire logic [15:0] filtOutX,
    input wire logic        sampleValid,
    input wire logic        sampleOk,
    // control
    input wire logic [7:0]  powerConfigOut,
    input wire logic        softResetPulse
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    wire offWr = regWrStb && ifReady && regAddr >= 8'h71 && regAddr <= 8'h73;

    AST_RD_ANSWER: assert property (regRdStb && ifReady |=> regRdValid)
        else $error("read not answered");
    AST_BOOT_SILENT: assert property (regRdStb && !ifReady |=> !regRdValid)
        else $error("read answered during boot");
    AST_BOOT_LEN: assert property ($fell(sys_rst) |-> !ifReady[*8] ##[1:6] ifReady)
        else $error("boot length wrong");
    AST_SRST_BOOT: assert property (softResetPulse |-> !ifReady[*6] ##[1:10] ifReady)
        else $error("soft reset boot wrong");
    AST_SRST_CAUSE: assert property
        (softResetPulse |-> $past(regWrStb && regAddr == 8'h7e && regWrData == 8'hb6))
        else $error("soft reset without command");
    AST_VALID_CAUSE: assert property (sampleValid |-> $past(sampleStb))
        else $error("sample valid without strobe");
    AST_SAME_CORR: assert property (sampleStb && rawX == filtX |=> rawOutX == filtOutX)
        else $error("raw and filtered corrected differently");
    AST_WR_INVALID: assert property (offWr && sampleStb |=> !sampleOk)
        else $error("sample after offset write marked ok");
    AST_WR_NEXT_INVALID: assert property (offWr ##2 sampleStb |=> !sampleOk)
        else $error("first sample after offset write marked ok");
    AST_PWR_RESET: assert property ($fell(sys_rst) |-> powerConfigOut == 8'h03)
        else $error("power config reset value wrong");

    COV_SRST: cover property (softResetPulse);
    COV_BAD_SAMPLE: cover property (sampleValid && !sampleOk);
    COV_READ: cover property (regRdValid);
endmodule // otnc_offset_trim_nvm_props

bind otnc_offset_trim_nvm otnc_offset_trim_nvm_props u_props (
    .clk(clk), .sys_rst(sys_rst), .regWrStb(regWrStb), .regRdStb(regRdStb),
    .regAddr(regAddr), .regWrData(regWrData), .regRdValid(regRdValid), .ifReady(ifReady),
    .sampleStb(sampleStb), .rawX(rawX), .filtX(filtX), .rawOutX(rawOutX),
    .filtOutX(filtOutX), .sampleValid(sampleValid), .sampleOk(sampleOk),
    .powerConfigOut(powerConfigOut), .softResetPulse(softResetPulse));

// File: test/otnc_offset_trim_nvm_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin n_mismatch++; \
    $display("ERROR %s expected %h seen %h", n, e, a); end end
module otnc_offset_trim_nvm_tb;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        sampleStb = 1'b0;
    logic        en = 1'b0;
    logic [15:0] rawIn [0:2];
    logic [15:0] filtIn [0:2];
    wire  [15:0] rawOut [0:2];
    wire  [15:0] filtOut [0:2];
    logic [7:0]  off [0:2];
    logic [7:0]  d;
    logic [7:0]  ra [0:11] = '{8'h7c, 8'h70, 8'h71, 8'h72, 8'h73, 8'h6a,
                               8'h6b, 8'h6d, 8'h7d, 8'h5f, 8'h5e, 8'h60};
    wire  [7:0]  regAddr, regWrData, regRdData, powerConfigOut, featureOut;
    wire         regWrStb, regRdStb, regRdValid, ifReady, sampleValid, sampleOk, softResetPulse;
    int          n_mismatch = 0;
    int          tests_run = 0;
    int          cyc = 0;

    always #5 clk = ~clk;

    otnc_host_model host (.clk(clk), .regWrStb(regWrStb), .regRdStb(regRdStb),
        .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
        .regRdValid(regRdValid));
    otnc_offset_trim_nvm #(.BOOT_CYCLES(10), .PROG_CYCLES(20)) dut (.clk(clk),
        .sys_rst(sys_rst), .regWrStb(regWrStb), .regRdStb(regRdStb), .regAddr(regAddr),
        .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid),
        .ifReady(ifReady), .sampleStb(sampleStb), .rawX(rawIn[0]), .rawY(rawIn[1]),
        .rawZ(rawIn[2]), .filtX(filtIn[0]), .filtY(filtIn[1]), .filtZ(filtIn[2]),
        .rawOutX(rawOut[0]), .rawOutY(rawOut[1]), .rawOutZ(rawOut[2]),
        .filtOutX(filtOut[0]), .filtOutY(filtOut[1]), .filtOutZ(filtOut[2]),
        .sampleValid(sampleValid), .sampleOk(sampleOk), .powerConfigOut(powerConfigOut),
        .featureOut(featureOut), .softResetPulse(softResetPulse));

    function automatic logic [15:0] corr(logic [15:0] s, logic [7:0] o, logic e);
        int v;
        v = $signed(s) + (e ? $signed(o) * 16 : 0);
        return v > 32767 ? 16'h7fff : (v < -32768 ? 16'h8000 : v[15:0]);
    endfunction
    task automatic tally_and_finish();
        if (n_mismatch == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic boot();
        repeat (40) if (!ifReady) @(negedge clk);
        `CHK("ifReady", 1'b1, ifReady)
    endtask
    task automatic rc(logic [7:0] a, logic [7:0] e);
        host.rd(a, d);
        `CHK("regRdData", e, d)
    endtask
    task automatic smp(logic [15:0] r, logic [15:0] f, logic ok);
        @(negedge clk);
        sampleStb = 1'b1;
        foreach (rawIn[i]) begin
            rawIn[i] = r ^ 16'(i);
            filtIn[i] = f;
        end
        @(negedge clk);
        sampleStb = 1'b0;
        `CHK("sampleValid", 1'b1, sampleValid)
        `CHK("sampleOk", ok, sampleOk)
        foreach (rawIn[i]) begin
            `CHK("rawOut", corr(rawIn[i], off[i], en), rawOut[i])
            `CHK("filtOut", corr(filtIn[i], off[i], en), filtOut[i])
        end
    endtask
    task automatic set_off(int i, logic [7:0] v);
        off[i] = v;
        host.wr(8'(8'h71 + i), v);
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    initial begin
        void'($urandom(32'h6244));
        foreach (rawIn[i]) begin
            rawIn[i] = 16'h0000;
            filtIn[i] = 16'h0000;
            off[i] = 8'h00;
        end
        repeat (10) @(negedge clk);
        sys_rst = 1'b0;
        boot();
        host.wr(8'h5e, 8'h5a);
        foreach (ra[i]) rc(ra[i], i == 0 ? 8'h03 : 8'h00);
        host.wr(8'h7c, 8'h02);
        `CHK("powerConfigOut", 8'h02, powerConfigOut)
        host.wr(8'h5e, 8'h5a);
        rc(8'h5e, 8'h5a);
        `CHK("featureOut", 8'h5a, featureOut)
        host.wr(8'h70, 8'h08);
        en = 1'b1;
        foreach (off[i]) set_off(i, 8'($urandom));
        smp(16'($urandom), 16'($urandom), 1'b0);
        repeat (20) smp(16'($urandom), 16'($urandom), 1'b1);
        set_off(0, 8'h7f);
        smp(16'h7ff0, 16'h7ff0, 1'b0);
        set_off(0, 8'h80);
        smp(16'h8000, 16'h8005, 1'b0);
        host.wr(8'h70, 8'h00);
        en = 1'b0;
        smp(16'($urandom), 16'($urandom), 1'b1);
        host.wr(8'h7c, 8'h03);
        host.wr(8'h6a, 8'h02);
        host.wr(8'h7e, 8'ha0);
        host.rd(8'h03, d);
        `CHK("cmdRdy", 1'b1, d[4])
        foreach (off[i]) off[i] = 8'($urandom);
        host.prog_start({off[2], off[1], off[0], 8'h08});
        host.rd(8'h03, d);
        `CHK("cmdRdy", 1'b0, d[4])
        rc(8'h7d, 8'h00);
        host.wr(8'h7d, 8'h05);
        host.prog_wait();
        rc(8'h03, 8'h10);
        rc(8'h7d, 8'h00);
        rc(8'h72, off[1]);
        host.wr(8'h71, 8'h11);
        rc(8'h71, 8'h11);
        host.wr(8'h7e, 8'hb6);
        `CHK("softResetPulse", 1'b1, softResetPulse)
        rc(8'h71, 8'hxx);
        boot();
        foreach (off[i]) rc(8'(8'h71 + i), off[i]);
        rc(8'h70, 8'h08);
        rc(8'h7c, 8'h03);
        tally_and_finish();
    end
endmodule // otnc_offset_trim_nvm_tb
